// *** hdl/block_write_command_decoder.sv ***
// decoder for short, ten- and twelve-byte block-write descriptors with protection handling
//
// What this block does
// - opcode 0ah: 21-bit address from byte1[4:0], bytes 2-3; byte 4 count.
// - opcode 2ah: 32-bit address bytes 2-5, 16-bit count bytes 7-8.
// - opcode aah: 32-bit address bytes 2-5, 32-bit count bytes 6-9.
// - zero count still positions, moves no data, completes good.
// - low-priority hint overrides configured cache retention; else configured applies.
// - force-media-write defers good status until data is on media.
// - nonvolatile-cache bit accepted with either value and ignored.
// - short write with protection: guard is a computed crc of block.
// - short write reference tag: low address bytes (type one) or fixed.
// - short write application tag ffffh when tag owner bit set.
// - unprotected medium with nonzero selector is rejected as illegal field.
// - selector zero: device generates protection fields itself when formatted.
// - selector one checks guard and reference tag.
// - selector two checks reference only; three nothing; four guard only.
// - selectors five to seven are reserved, rejected as illegal field.
// - failed check aborts command, code names the failing field.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module block_write_command_decoder (
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   // descriptor bytes, one per strobe, byte 0 first
   input  wire logic        cdb_valid_in,
   input  wire logic [7:0]  cdb_byte_in,
   input  wire logic        cdb_last_in,
   // received block stream: one word of user data per beat
   input  wire logic        blk_valid_in,
   input  wire logic [31:0] blk_data_in,
   input  wire logic        blk_last_in,
   input  wire logic [15:0] blk_guard_in,
   input  wire logic [31:0] blk_ref_in,
   input  wire logic        media_done_in,
   input  wire logic        cache_retain_low_in,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // decoded command and results
   output logic             cmd_start_out,
   output logic [31:0]      start_block_address_out,
   output logic [31:0]      block_count_out,
   output logic             cache_low_priority_out,
   output logic             data_phase_out,
   output logic             gen_valid_out,
   output logic [15:0]      gen_guard_out,
   output logic [31:0]      gen_ref_out,
   output logic [15:0]      gen_app_out,
   output logic             done_out,
   output logic [1:0]       status_out,
   output logic [1:0]       fail_field_out,
   output logic             irq_out
);
   typedef enum logic [2:0] {S_IDLE, S_GATHER, S_EVAL, S_DATA, S_MEDIA, S_DONE} state_t;

   state_t                  state_q;
   logic [7:0]              cdb_q [0:9];
   logic [3:0]              idx_q;
   logic [31:0]             cfg_q;
   logic [wr_cmd_pkg::IRQ_W-1:0] irq_stat_q;
   logic [wr_cmd_pkg::IRQ_W-1:0] irq_mask_q;
   logic [31:0]             remain_q;
   logic [31:0]             ref_q;
   logic [15:0]             crc_q;
   logic                    fmw_q;
   logic [2:0]              sel_q;
   logic                    wr_pend_q;
   logic [7:0]              wr_addr_q;
   logic [31:0]             wr_data_q;
   logic                    aw_have_q;
   logic                    w_have_q;

   // field extraction, msb byte first (lowest byte number most significant)
   wr_cmd_pkg::cmd_kind_t   kind;
   logic [31:0]             dec_addr;
   logic [31:0]             dec_count;
   logic [2:0]              dec_sel;
   logic                    protection_enabled_flag;
   logic [2:0]              ptype;
   logic                    sel_reserved;
   logic                    chk_guard;
   logic                    chk_ref;
   logic [15:0]             crc_next;
   logic [wr_cmd_pkg::IRQ_W-1:0] irq_set;

   assign protection_enabled_flag = cfg_q[wr_cmd_pkg::CFG_PROT_BIT];
   assign ptype   = cfg_q[wr_cmd_pkg::CFG_PTYPE_LSB +: 3];

   always_comb begin
      unique case (cdb_q[0])
         wr_cmd_pkg::OP_WRITE_SHORT:  kind = wr_cmd_pkg::KIND_SHORT;
         wr_cmd_pkg::OP_WRITE_TEN:    kind = wr_cmd_pkg::KIND_TEN;
         wr_cmd_pkg::OP_WRITE_TWELVE: kind = wr_cmd_pkg::KIND_TWELVE;
         default:                     kind = wr_cmd_pkg::KIND_OTHER;
      endcase
   end

   // decode address, count and selector per descriptor form
   always_comb begin
      dec_addr  = {cdb_q[2], cdb_q[3], cdb_q[4], cdb_q[5]};
      dec_count = {cdb_q[6], cdb_q[7], cdb_q[8], cdb_q[9]};
      dec_sel   = cdb_q[1][wr_cmd_pkg::SEL_LSB +: 3];
      unique case (kind)
         wr_cmd_pkg::KIND_SHORT: begin
            dec_addr  = {11'h000, cdb_q[1][4:0], cdb_q[2], cdb_q[3]};
            dec_count = {24'h000000, cdb_q[4]};
            dec_sel   = wr_cmd_pkg::SEL_NONE;
         end
         wr_cmd_pkg::KIND_TEN: begin
            dec_count = {16'h0000, cdb_q[7], cdb_q[8]};
         end
         wr_cmd_pkg::KIND_TWELVE, wr_cmd_pkg::KIND_OTHER: begin
         end
      endcase
   end

   // selector validity and which fields get checked
   always_comb begin
      sel_reserved = dec_sel > wr_cmd_pkg::SEL_GUARD;
      chk_guard    = (sel_q == wr_cmd_pkg::SEL_ALL) ||
                     (sel_q == wr_cmd_pkg::SEL_GUARD);
      chk_ref      = (sel_q == wr_cmd_pkg::SEL_ALL) ||
                     (sel_q == wr_cmd_pkg::SEL_NOGUARD);
   end

   // serial crc over one data word, msb first
   always_comb begin
      crc_next = crc_q;
      for (int i = 31; i >= 0; i--) begin
         if (crc_next[15] ^ blk_data_in[i]) begin
            crc_next = {crc_next[14:0], 1'b0} ^ wr_cmd_pkg::CRC_POLY;
         end else begin
            crc_next = {crc_next[14:0], 1'b0};
         end
      end
   end

   // descriptor byte capture
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         idx_q <= 4'h0;
         for (int i = 0; i < 10; i++) begin
            cdb_q[i] <= 8'h00;
         end
      end else if (cdb_valid_in && (state_q == S_IDLE || state_q == S_GATHER)) begin
         if (idx_q < 4'ha) begin
            cdb_q[idx_q] <= cdb_byte_in;
         end
         idx_q <= cdb_last_in ? 4'h0 : idx_q + 4'h1;
      end
   end

   // command sequencer
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state_q                 <= S_IDLE;
         cmd_start_out           <= 1'b0;
         start_block_address_out <= 32'h00000000;
         block_count_out         <= 32'h00000000;
         cache_low_priority_out  <= 1'b0;
         data_phase_out          <= 1'b0;
         done_out                <= 1'b0;
         status_out              <= wr_cmd_pkg::ST_GOOD;
         fail_field_out          <= wr_cmd_pkg::FAIL_NONE;
         remain_q                <= 32'h00000000;
         fmw_q                   <= 1'b0;
         sel_q                   <= wr_cmd_pkg::SEL_NONE;
      end else begin
         cmd_start_out <= 1'b0;
         done_out      <= 1'b0;
         unique case (state_q)
            S_IDLE, S_GATHER: begin
               if (cdb_valid_in) begin
                  state_q <= cdb_last_in ? S_EVAL : S_GATHER;
               end
            end
            S_EVAL: begin
               start_block_address_out <= dec_addr;
               block_count_out         <= dec_count;
               remain_q                <= dec_count;
               sel_q                   <= dec_sel;
               // nonvolatile-cache bit deliberately not sampled
               fmw_q                   <= (kind != wr_cmd_pkg::KIND_SHORT) &&
                                          cdb_q[1][wr_cmd_pkg::FMW_BIT];
               cache_low_priority_out  <= ((kind != wr_cmd_pkg::KIND_SHORT) &&
                                          cdb_q[1][wr_cmd_pkg::HINT_BIT]) ||
                                          cache_retain_low_in;
               fail_field_out          <= wr_cmd_pkg::FAIL_NONE;
               if (kind == wr_cmd_pkg::KIND_OTHER || sel_reserved ||
                   (!protection_enabled_flag && dec_sel != wr_cmd_pkg::SEL_NONE)) begin
                  status_out <= wr_cmd_pkg::ST_ILLEGAL;
                  state_q    <= S_DONE;
               end else begin
                  status_out    <= wr_cmd_pkg::ST_GOOD;
                  cmd_start_out <= 1'b1;                                  // positioning always
                  // zero count skips the data phase, completes good
                  data_phase_out <= dec_count != 32'h00000000;
                  state_q       <= (dec_count == 32'h00000000) ? S_DONE : S_DATA;
               end
            end
            S_DATA: begin
               if (blk_valid_in && blk_last_in) begin
                  // supplied fields only present for nonzero selectors
                  if (chk_guard && blk_guard_in != crc_next) begin
                     fail_field_out <= wr_cmd_pkg::FAIL_GUARD;
                     status_out     <= wr_cmd_pkg::ST_ABORTED;
                     data_phase_out <= 1'b0;
                     state_q        <= S_DONE;
                  end else if (chk_ref && blk_ref_in != ref_q) begin
                     fail_field_out <= wr_cmd_pkg::FAIL_REF;
                     status_out     <= wr_cmd_pkg::ST_ABORTED;
                     data_phase_out <= 1'b0;
                     state_q        <= S_DONE;
                  end else if (remain_q == 32'h00000001) begin
                     data_phase_out <= 1'b0;
                     state_q        <= fmw_q ? S_MEDIA : S_DONE;
                  end
                  remain_q <= remain_q - 32'h00000001;
               end
            end
            S_MEDIA: begin
               // good status held back until the media commits
               if (media_done_in) begin
                  state_q <= S_DONE;
               end
            end
            S_DONE: begin
               done_out <= 1'b1;
               state_q  <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // per-block protection generation and expected reference tag
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         crc_q         <= wr_cmd_pkg::CRC_INIT;
         ref_q         <= 32'h00000000;
         gen_valid_out <= 1'b0;
         gen_guard_out <= 16'h0000;
         gen_ref_out   <= 32'h00000000;
         gen_app_out   <= 16'h0000;
      end else begin
         gen_valid_out <= 1'b0;
         if (state_q == S_EVAL) begin
            crc_q <= wr_cmd_pkg::CRC_INIT;
            ref_q <= dec_addr;
         end else if (state_q == S_DATA && blk_valid_in) begin
            crc_q <= blk_last_in ? wr_cmd_pkg::CRC_INIT : crc_next;
            if (blk_last_in) begin
               ref_q <= ref_q + 32'h00000001;
               // device-generated fields when the initiator sends none
               gen_valid_out <= protection_enabled_flag && sel_q == wr_cmd_pkg::SEL_NONE;
               gen_guard_out <= crc_next;
               gen_ref_out   <= (ptype == wr_cmd_pkg::PTYPE_TWO) ?
                                wr_cmd_pkg::REF_TAG_FIXED : ref_q;
               gen_app_out   <= cfg_q[wr_cmd_pkg::CFG_ATO_BIT] ?
                                wr_cmd_pkg::APP_TAG_FIXED : 16'h0000;
            end
         end
      end
   end

   // completion events; set beats a same-cycle clear
   assign irq_set = {done_out && status_out == wr_cmd_pkg::ST_ABORTED,
                     done_out && status_out == wr_cmd_pkg::ST_ILLEGAL,
                     done_out && status_out == wr_cmd_pkg::ST_GOOD};

   // axi write path: address and data taken in either order
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= wr_cmd_pkg::RESP_OKAY;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         wr_pend_q     <= 1'b0;
         wr_addr_q     <= 8'h00;
         wr_data_q     <= 32'h00000000;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
         wr_pend_q     <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            wr_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q  <= 1'b1;
            wr_data_q <= s_axi_wdata;
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            wr_pend_q    <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_addr_q == wr_cmd_pkg::REG_CONFIG ||
                             wr_addr_q == wr_cmd_pkg::REG_IRQ_STAT ||
                             wr_addr_q == wr_cmd_pkg::REG_IRQ_MASK) ?
                            wr_cmd_pkg::RESP_OKAY : wr_cmd_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register writes; strobes ignored, all writable fields sit in the low byte
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         cfg_q      <= wr_cmd_pkg::CFG_RESET;
         irq_mask_q <= '0;
         irq_stat_q <= '0;
         irq_out    <= 1'b0;
      end else begin
         if (wr_pend_q && wr_addr_q == wr_cmd_pkg::REG_CONFIG) begin
            cfg_q <= wr_data_q;
         end
         if (wr_pend_q && wr_addr_q == wr_cmd_pkg::REG_IRQ_MASK) begin
            irq_mask_q <= wr_data_q[wr_cmd_pkg::IRQ_W-1:0];
         end
         if (wr_pend_q && wr_addr_q == wr_cmd_pkg::REG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wr_data_q[wr_cmd_pkg::IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         irq_out <= |(irq_stat_q & irq_mask_q);
      end
   end

   // axi read path, answer one cycle after address is taken
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= wr_cmd_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= wr_cmd_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
               wr_cmd_pkg::REG_CONFIG:   s_axi_rdata <= cfg_q;
               wr_cmd_pkg::REG_STATUS:   s_axi_rdata <= {24'h000000, 1'b0, 3'(state_q),
                                                         fail_field_out, status_out};
               wr_cmd_pkg::REG_IRQ_STAT: s_axi_rdata <= {29'h00000000, irq_stat_q};
               wr_cmd_pkg::REG_IRQ_MASK: s_axi_rdata <= {29'h00000000, irq_mask_q};
               wr_cmd_pkg::REG_ADDR:     s_axi_rdata <= start_block_address_out;
               wr_cmd_pkg::REG_COUNT:    s_axi_rdata <= block_count_out;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= wr_cmd_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks on the command flow
   sequence illegal_eval_s;
      state_q == S_EVAL && (kind == wr_cmd_pkg::KIND_OTHER || sel_reserved);
   endsequence
   sequence done_illegal_s;
      ##2 done_out && status_out == wr_cmd_pkg::ST_ILLEGAL;
   endsequence

   AST_RESERVED_SEL: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      illegal_eval_s |-> done_illegal_s) else $error("reserved selector not rejected");
   AST_UNPROT_SEL: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      state_q == S_EVAL && !protection_enabled_flag && dec_sel != wr_cmd_pkg::SEL_NONE |-> ##1
      status_out == wr_cmd_pkg::ST_ILLEGAL) else $error("selector on bare medium accepted");
   AST_ZERO_COUNT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      state_q == S_EVAL && !sel_reserved && kind != wr_cmd_pkg::KIND_OTHER && dec_count == 0 &&
      (protection_enabled_flag || dec_sel == wr_cmd_pkg::SEL_NONE) |-> ##1 cmd_start_out && !data_phase_out
      ##1 done_out && status_out == wr_cmd_pkg::ST_GOOD) else $error("zero count mishandled");
   AST_SHORT_ADDR: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      state_q == S_EVAL && kind == wr_cmd_pkg::KIND_SHORT |-> ##1
      start_block_address_out[31:21] == 0 && block_count_out[31:8] == 0)
      else $error("short address or count too wide");
   AST_TEN_COUNT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      state_q == S_EVAL && kind == wr_cmd_pkg::KIND_TEN |-> ##1
      block_count_out == {16'h0000, $past(cdb_q[7]), $past(cdb_q[8])})
      else $error("ten-byte count wrong");
   AST_MEDIA_WAIT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      state_q == S_MEDIA && !media_done_in |=> !done_out) else $error("good before media");
   AST_GUARD_FAIL: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      state_q == S_DATA && blk_valid_in && blk_last_in && chk_guard &&
      blk_guard_in != crc_next |-> ##1 fail_field_out == wr_cmd_pkg::FAIL_GUARD ##1
      done_out && status_out == wr_cmd_pkg::ST_ABORTED) else $error("guard fail not aborted");
   AST_REF_TAG: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      gen_valid_out && ptype == wr_cmd_pkg::PTYPE_TWO |-> gen_ref_out == wr_cmd_pkg::REF_TAG_FIXED)
      else $error("type two reference tag wrong");
   AST_NOCHECK: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      state_q == S_DATA && sel_q == wr_cmd_pkg::SEL_NOCHECK && blk_valid_in |=>
      fail_field_out == wr_cmd_pkg::FAIL_NONE) else $error("selector three checks a field");
endmodule
`default_nettype wire

// *** hdl/wr_cmd_pkg.sv ***
// constants, register map and types for the block-write command decoder
package wr_cmd_pkg;
   // operation codes
   localparam logic [7:0]  OP_WRITE_SHORT  = 8'h0a;
   localparam logic [7:0]  OP_WRITE_TEN    = 8'h2a;
   localparam logic [7:0]  OP_WRITE_TWELVE = 8'haa;
   // byte-1 field positions
   localparam int          SEL_LSB         = 5;
   localparam int          HINT_BIT        = 4;
   localparam int          FMW_BIT         = 3;
   localparam int          NVW_BIT         = 1;
   // protection check selector codes
   localparam logic [2:0]  SEL_NONE        = 3'h0;
   localparam logic [2:0]  SEL_ALL         = 3'h1;
   localparam logic [2:0]  SEL_NOGUARD     = 3'h2;
   localparam logic [2:0]  SEL_NOCHECK     = 3'h3;
   localparam logic [2:0]  SEL_GUARD       = 3'h4;
   // protection types
   localparam logic [2:0]  PTYPE_ONE       = 3'h0;
   localparam logic [2:0]  PTYPE_TWO       = 3'h1;
   // generated tag values
   localparam logic [31:0] REF_TAG_FIXED   = 32'h0fffffff;
   localparam logic [15:0] APP_TAG_FIXED   = 16'hffff;
   localparam logic [15:0] CRC_POLY        = 16'h8bb7;
   localparam logic [15:0] CRC_INIT        = 16'h0000;
   // completion status codes
   localparam logic [1:0]  ST_GOOD         = 2'h0;
   localparam logic [1:0]  ST_ILLEGAL      = 2'h1;
   localparam logic [1:0]  ST_ABORTED      = 2'h2;
   // failing field codes
   localparam logic [1:0]  FAIL_NONE       = 2'h0;
   localparam logic [1:0]  FAIL_GUARD      = 2'h1;
   localparam logic [1:0]  FAIL_REF        = 2'h2;
   // register byte offsets
   localparam logic [7:0]  REG_CONFIG      = 8'h00;
   localparam logic [7:0]  REG_STATUS      = 8'h04;
   localparam logic [7:0]  REG_IRQ_STAT    = 8'h08;
   localparam logic [7:0]  REG_IRQ_MASK    = 8'h0c;
   localparam logic [7:0]  REG_ADDR        = 8'h10;
   localparam logic [7:0]  REG_COUNT       = 8'h14;
   // config fields
   localparam int          CFG_PROT_BIT    = 0;
   localparam int          CFG_ATO_BIT     = 1;
   localparam int          CFG_PTYPE_LSB   = 4;
   localparam logic [31:0] CFG_RESET       = 32'h00000000;
   // interrupt bits and width; axi response codes
   localparam int          IRQ_DONE        = 0;
   localparam int          IRQ_ILLEGAL     = 1;
   localparam int          IRQ_ABORT       = 2;
   localparam int          IRQ_W           = 3;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0] {
      KIND_SHORT,
      KIND_TEN,
      KIND_TWELVE,
      KIND_OTHER
   } cmd_kind_t;
endpackage

// *** tb/tb_block_write_command_decoder.sv ***
// self-checking bench for the block-write command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_block_write_command_decoder;
   logic        clk = 0, rst = 1, go = 0, awv = 0, wv = 0, br = 0, hv, hl;
   logic        bv = 0, md = 0, crl = 0, arv = 0, rr = 0;
   logic [95:0] cdb = '0;
   logic [3:0]  len = 4'h0;
   logic [7:0]  aa = 8'h00, ar = 8'h00, hb;
   logic [31:0] wd = 32'h0, bd = 32'h0, r = 32'h6469f748;
   int          err_count = 0, n_compared = 0;
   always #12.5 clk = ~clk;
   wr_host u_host (.clk_in(clk), .go_in(go), .cdb_in(cdb), .len_in(len), .valid_out(hv),
      .byte_out(hb), .last_out(hl));
   block_write_command_decoder u_dut (.ref_clk_in(clk), .reset_in(rst), .cdb_valid_in(hv),
      .cdb_byte_in(hb), .cdb_last_in(hl), .blk_valid_in(bv), .blk_data_in(bd),
      .blk_last_in(1'b1), .blk_guard_in(bd[15:0]), .blk_ref_in(bd), .media_done_in(md),
      .cache_retain_low_in(crl), .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(br), .s_axi_araddr(ar),
      .s_axi_arvalid(arv), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
      .s_axi_rvalid(), .s_axi_rready(rr), .cmd_start_out(), .start_block_address_out(),
      .block_count_out(), .cache_low_priority_out(), .data_phase_out(), .gen_valid_out(),
      .gen_guard_out(), .gen_ref_out(), .gen_app_out(), .done_out(), .status_out(),
      .fail_field_out(), .irq_out());
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // guard of a one-word block: msb first, from the package polynomial and seed
   function automatic logic [15:0] crc(input logic [31:0] d);
      logic [15:0] c = wr_cmd_pkg::CRC_INIT;
      for (int i = 31; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? wr_cmd_pkg::CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one register write; each channel released at the edge where it is taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int t;
      bit got;
      aa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      got = 0;
      for (t = 0; t < 50 && !got; t++) begin
         @(posedge clk);
         if (u_dut.s_axi_awready === 1'b1) awv <= 1'b0;
         if (u_dut.s_axi_wready === 1'b1) wv <= 1'b0;
         got = (u_dut.s_axi_bvalid === 1'b1);
      end
      br <= 1'b0;
      if (!got) begin err_count++; finish_test(); end
   endtask
   // one register read; data taken at the edge where rvalid is seen
   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      int t;
      ar <= a; arv <= 1'b1; rr <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge clk);
         if (u_dut.s_axi_arready === 1'b1) arv <= 1'b0;
         if (u_dut.s_axi_rvalid === 1'b1) break;
      end
      d = u_dut.s_axi_rdata;
      rr <= 1'b0;
      if (t == 50) begin err_count++; finish_test(); end
   endtask
   // checks address, count, hint and status against the expected values passed in by the caller
   task automatic run(input logic [95:0] c, input logic [3:0] n, input logic [1:0] st,
                      input logic [31:0] a, input logic [31:0] k, input logic h);
      int t;
      logic [31:0] d;
      @(posedge clk) begin cdb <= c; len <= n; go <= 1'b1; bd <= a; crl <= r[3]; end
      @(posedge clk) go <= 1'b0;
      for (t = 0; t < 60; t++) begin
         @(posedge clk);
         #1;
         r = lfsr(r);
         md <= r[0];
         // one single-word block per cycle while the block asks for data
         bv <= u_dut.data_phase_out;
         if (u_dut.cmd_start_out === 1'b1) begin
            chk(u_dut.start_block_address_out, a);
            chk(u_dut.block_count_out, k);
            chk({31'h0, u_dut.cache_low_priority_out}, {31'h0, h | crl});
         end
         if (u_dut.gen_valid_out === 1'b1) begin
            chk({16'h0, u_dut.gen_guard_out}, {16'h0, crc(a)});
            chk(u_dut.gen_ref_out, a);
            chk({16'h0, u_dut.gen_app_out}, {16'h0, wr_cmd_pkg::APP_TAG_FIXED});
         end
         if (u_dut.done_out === 1'b1) break;
      end
      if (t == 60) begin err_count++; finish_test(); end
      chk({30'h0, u_dut.status_out}, {30'h0, st});
      chk({30'h0, u_dut.fail_field_out}, {30'h0, (st == wr_cmd_pkg::ST_ABORTED) ?
          wr_cmd_pkg::FAIL_GUARD : wr_cmd_pkg::FAIL_NONE});
      axr(wr_cmd_pkg::REG_ADDR, d);
      chk(d, a);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      axw(wr_cmd_pkg::REG_IRQ_MASK, 32'h7);
      for (int i = 0; i < 3; i++) begin
         r = lfsr(r);
         run({wr_cmd_pkg::OP_WRITE_SHORT, 3'h0, r[20:0], 64'h0}, 4'h6,
             wr_cmd_pkg::ST_GOOD, {11'h0, r[20:0]}, 32'h0, 1'b0);
         run({wr_cmd_pkg::OP_WRITE_TEN, 3'h0, r[0], 2'h0, r[2], 1'b0, r, 48'h0}, 4'ha,
             wr_cmd_pkg::ST_GOOD, r, 32'h0, r[0]);
         run({wr_cmd_pkg::OP_WRITE_TWELVE, 3'h0, r[1], 2'h0, r[3], 1'b0, r, 48'h0}, 4'hc,
             wr_cmd_pkg::ST_GOOD, r, 32'h0, r[1]);
      end
      for (int s = 1; s < 8; s++)
         run({wr_cmd_pkg::OP_WRITE_TEN, 3'(s), 5'h0, r, 48'h0}, 4'ha,
             wr_cmd_pkg::ST_ILLEGAL, r, 32'h0, 1'b0);
      // protected medium, type one, tag owner set; one block, force-media-write on
      axw(wr_cmd_pkg::REG_CONFIG, 32'h3);
      for (int s = 0; s < 5; s++)
         run({wr_cmd_pkg::OP_WRITE_TEN, 3'(s), 5'h8, r, 8'h0, 16'h1, 24'h0}, 4'ha,
             ((s == 1 || s == 4) && r[15:0] != crc(r)) ? wr_cmd_pkg::ST_ABORTED :
             wr_cmd_pkg::ST_GOOD, r, 32'h1, 1'b0);
      chk({31'h0, u_dut.irq_out}, 32'h1);
      axw(wr_cmd_pkg::REG_IRQ_STAT, 32'h7);
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, u_dut.irq_out}, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire

// *** tb/wr_host.sv ***
// initiator model that sends one descriptor, one byte a cycle, byte 0 first
`timescale 1ns/10ps
`default_nettype none
module wr_host (
   input  wire logic        clk_in,
   input  wire logic        go_in,
   input  wire logic [95:0] cdb_in,
   input  wire logic [3:0]  len_in,
   output logic             valid_out = 1'b0,
   output logic [7:0]       byte_out = 8'h00,
   output logic             last_out = 1'b0
);
   int idx = 0;
   // byte lane inverts every cycle between frames, so the last byte sent reappears every other cycle
   always @(posedge clk_in) begin
      if (go_in) begin
         valid_out <= 1'b1;
         byte_out  <= cdb_in[95:88];
         last_out  <= (len_in == 4'h1);
         idx       <= 1;
      end else if (valid_out && !last_out) begin
         byte_out <= cdb_in[95-8*idx -: 8];
         last_out <= (idx == len_in - 1);
         idx      <= idx + 1;
      end else begin
         valid_out <= 1'b0;
         last_out  <= 1'b0;
         byte_out  <= ~byte_out;
      end
   end
endmodule
`default_nettype wire
